// file: hdl/isorw_pkg.sv
package isorw_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int REFRESH_IDLE_NS   = 140000;
  localparam int WATCHDOG_NS       = 200000;
  localparam int RECOVERY_US       = 150;
  localparam int PULSE_WIDTH_NS    = 1;
  // Least times round up, never below one cycle
  localparam int REFRESH_CYCLES    = (REFRESH_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WATCHDOG_CYCLES   = (WATCHDOG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYCLES      = (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W             = 16;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic RST_INPUT_LEVEL = 1'b0;
  localparam logic RST_LATCH_LEVEL = 1'b0;

  // ==========================================================================
  // Barrier pulse carrier
  // ==========================================================================
  typedef struct packed {
    logic set;
    logic reset;
  } isorw_pulse_t;

endpackage

// file: hdl/isorw_sync3.sv
`timescale 1ns/1ps
module isorw_sync3
  import isorw_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous level in, filtered level out
  input  wire logic async_in,
  input  wire logic rst_level,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // Stages start at the idle level so no false change follows reset
      s1 <= rst_level;
      s2 <= rst_level;
      s3 <= rst_level;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change accepted once second and third stage agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level <= rst_level;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule

// file: hdl/isorw_channel.sv
`timescale 1ns/1ps
// Functional notes
// - Each input edge sends one short pulse across the barrier marking rise or fall.
// - The receive decoder is a latch set by rise pulses, reset by fall pulses, holding otherwise.
// - With refresh enabled and input idle beyond about 140 us, refresh pulses of the input level repeat.
// - With watchdog enabled and no pulse for about 200 us, the output goes to the default level.
// - The default level is a build-time parameter of the channel.
// - Refresh and watchdog run while the enables are low and are off while they are high.
// - In low-power mode the output changes only on input edges; an earlier level is not forwarded.
// - With refresh and watchdog off and input side dead, the output holds its last level.
// - With refresh on, the output follows the input again within a bounded time after power returns.
module isorw_channel
  import isorw_pkg::*;
#(
  parameter logic DEFAULT_LEVEL = 1'b1,
  parameter int   REFRESH_CYC   = REFRESH_CYCLES,
  parameter int   WATCHDOG_CYC  = WATCHDOG_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Side 1
  input  wire logic channel_a_input,
  input  wire logic side1_enable_b,
  input  wire logic side1_powered,
  // Side 2
  input  wire logic side2_enable_b,
  output logic      channel_a_output,
  output logic      watchdog_tripped
);

  // ==========================================================================
  // Input conditioning
  // ==========================================================================
  logic in_level;
  logic en1_b;
  logic en2_b;
  logic prev_level;
  logic prev_valid;
  isorw_pulse_t tx_pulse;
  isorw_pulse_t rx_pulse;
  logic [CNT_W-1:0] refresh_cnt;
  logic [CNT_W-1:0] watchdog_cnt;
  logic edge_seen;
  logic refresh_due;
  logic tx_any;
  logic rx_any;

  // ==========================================================================
  // Receive mode
  // ==========================================================================
  typedef enum logic [2:0] {
    RX_LOW_POWER = 3'b001,
    RX_LIVE      = 3'b010,
    RX_DEAD      = 3'b100
  } isorw_rx_state_t;

  isorw_rx_state_t rx_state;
  isorw_rx_state_t next_rx_state;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Shared by refresh and watchdog, both fire once the count reaches limit - 1, which is limit cycles after the last pulse
  function automatic logic limit_reached(input logic [CNT_W-1:0] count, input int limit);
    return count >= CNT_W'(limit - 1);
  endfunction

  isorw_sync3 u_sync_in (
    .clk       (clk),
    .rst_b     (rst_b),
    .async_in  (channel_a_input),
    .rst_level (RST_INPUT_LEVEL),
    .level     (in_level)
  );

  isorw_sync3 u_sync_en1 (
    .clk       (clk),
    .rst_b     (rst_b),
    .async_in  (side1_enable_b),
    .rst_level (1'b1),
    .level     (en1_b)
  );

  isorw_sync3 u_sync_en2 (
    .clk       (clk),
    .rst_b     (rst_b),
    .async_in  (side2_enable_b),
    .rst_level (1'b1),
    .level     (en2_b)
  );

  // ==========================================================================
  // Transmit side
  // ==========================================================================
  // Unpowered input side sends nothing; first level after power is a baseline
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_level <= RST_INPUT_LEVEL;
      prev_valid <= 1'b0;
    end else begin
      prev_level <= in_level;
      prev_valid <= side1_powered;
    end
  end

  assign edge_seen   = side1_powered && prev_valid && (in_level != prev_level);
  assign refresh_due = side1_powered && !en1_b && limit_reached(refresh_cnt, REFRESH_CYC);
  assign tx_any      = edge_seen || refresh_due;

  // Idle timer restarts on every pulse sent
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refresh_cnt <= '0;
    end else if (tx_any || en1_b || !side1_powered) begin
      refresh_cnt <= '0;
    end else begin
      refresh_cnt <= refresh_cnt + CNT_W'(1);
    end
  end

  // One-cycle pulse; 1 ns rounds up to one 8 ns clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_pulse <= '0;
    end else begin
      tx_pulse.set   <= tx_any && in_level;
      tx_pulse.reset <= tx_any && !in_level;
    end
  end

  assign rx_pulse = tx_pulse;
  assign rx_any   = rx_pulse.set || rx_pulse.reset;

  // ==========================================================================
  // Receive side
  // ==========================================================================
  // Watchdog timer restarts on every pulse received
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      watchdog_cnt <= '0;
    end else if (rx_any || en2_b) begin
      watchdog_cnt <= '0;
    end else if (watchdog_cnt < CNT_W'(WATCHDOG_CYC)) begin
      watchdog_cnt <= watchdog_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_state <= RX_LOW_POWER;
    end else begin
      rx_state <= next_rx_state;
    end
  end

  // Dead stays dead until a pulse arrives or the watchdog is switched off
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      RX_LOW_POWER: begin
        if (!en2_b) begin
          next_rx_state = RX_LIVE;
        end
      end
      RX_LIVE: begin
        if (en2_b) begin
          next_rx_state = RX_LOW_POWER;
        end else if (!rx_any && limit_reached(watchdog_cnt, WATCHDOG_CYC)) begin
          next_rx_state = RX_DEAD;
        end
      end
      RX_DEAD: begin
        if (en2_b) begin
          next_rx_state = RX_LOW_POWER;
        end else if (rx_any) begin
          next_rx_state = RX_LIVE;
        end
      end
      default: begin
        next_rx_state = RX_LOW_POWER;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      watchdog_tripped <= 1'b0;
    end else begin
      watchdog_tripped <= (next_rx_state == RX_DEAD);
    end
  end

  // ==========================================================================
  // Decoder
  // ==========================================================================
  // Bistable decoder; pulses win over watchdog, so recovery needs one pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_a_output <= RST_LATCH_LEVEL;
    end else if (rx_pulse.set) begin
      channel_a_output <= 1'b1;
    end else if (rx_pulse.reset) begin
      channel_a_output <= 1'b0;
    end else if (next_rx_state == RX_DEAD) begin
      channel_a_output <= DEFAULT_LEVEL;
    end
    // Otherwise hold, also in low-power mode with input side dead
  end

endmodule

// file: dv/isorw_side1_model.sv
`timescale 1ns/1ps
module isorw_side1_model (
  // Clock and request
  input  wire logic clk,
  input  wire logic level_req,
  // Pin
  output logic      channel_a_input
);
  initial channel_a_input = 1'b0;
  // One falling edge late, so requests never race the pin
  always @(negedge clk) channel_a_input <= level_req;
endmodule

// file: dv/isorw_channel_sva.sv
`timescale 1ns/1ps
module isorw_channel_sva
  import isorw_pkg::*;
#(
  parameter logic DEFAULT_LEVEL = 1'b1,
  parameter int   REFRESH_CYC   = REFRESH_CYCLES,
  parameter int   WATCHDOG_CYC  = WATCHDOG_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic channel_a_input,
  input wire logic side1_enable_b,
  input wire logic side1_powered,
  input wire logic side2_enable_b,
  input wire logic channel_a_output,
  input wire logic watchdog_tripped
);
  logic live;
  logic last_in;
  int   idle;
  int   dead;
  assign live = !side1_enable_b && !side2_enable_b;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Counters saturate so long runs never wrap
  always_ff @(posedge clk) begin
    last_in <= channel_a_input;
    if (!rst_b || !side1_powered || !live || channel_a_input != last_in) idle <= 0;
    else if (idle < 999) idle <= idle + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_b || side1_powered || !live) dead <= 0;
    else if (dead < 999) dead <= dead + 1;
  end
  sequence lo8; (!channel_a_input && side1_powered)[*8]; endsequence
  sequence hi8; (channel_a_input && side1_powered)[*8]; endsequence
  rise_follow_a: assert property (lo8 ##1 hi8 |-> channel_a_output) else $error("rise lost");
  fall_follow_a: assert property (hi8 ##1 lo8 |-> !channel_a_output) else $error("fall lost");
  refresh_fix_a: assert property (idle == REFRESH_CYC + 16 |-> channel_a_output == channel_a_input)
    else $error("no refresh");
  live_quiet_a: assert property (idle > REFRESH_CYC + 16 |-> !watchdog_tripped) else $error("bad trip");
  dead_default_a: assert property (dead == WATCHDOG_CYC + 16 |-> channel_a_output == DEFAULT_LEVEL)
    else $error("no default");
  trip_level_a: assert property ($rose(watchdog_tripped) |-> ##[0:2] channel_a_output == DEFAULT_LEVEL)
    else $error("wrong default");
  trip_off_a: assert property (side2_enable_b[*6] |-> !watchdog_tripped) else $error("trip in low power");
  lp_hold_a: assert property ((side1_enable_b && side2_enable_b && (!side1_powered || $stable(channel_a_input)))[*8]
    |-> $stable(channel_a_output)) else $error("output moved");
endmodule
bind isorw_channel isorw_channel_sva #(.DEFAULT_LEVEL(DEFAULT_LEVEL), .REFRESH_CYC(REFRESH_CYC),
  .WATCHDOG_CYC(WATCHDOG_CYC)) i_isorw_channel_sva (.clk, .rst_b, .channel_a_input, .side1_enable_b,
  .side1_powered, .side2_enable_b, .channel_a_output, .watchdog_tripped);

// file: dv/isorw_channel_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; $display("wrong value %s %b %b", n, e, s); end end
module isorw_channel_tb;
  localparam int   REF = 20;
  localparam int   WDG = 30;
  localparam logic DEF = 1'b1;
  // Expected output from refresh mode, input power, input level and last level sent
  function automatic logic expect_out(input logic ref_on, input logic powered, input logic level, input logic last);
    if (powered) return level;
    return ref_on ? DEF : last;
  endfunction
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en_b = 1'b0;
  logic pwr = 1'b1;
  logic lvl = 1'b0;
  logic v = 1'b0;
  logic pin;
  logic out;
  logic trip;
  int   errors = 0;
  int   check_count = 0;
  always #4 clk = ~clk;
  isorw_side1_model i_isorw_side1_model (.clk(clk), .level_req(lvl), .channel_a_input(pin));
  // One enable feeds both sides so they always agree
  isorw_channel #(.DEFAULT_LEVEL(DEF), .REFRESH_CYC(REF), .WATCHDOG_CYC(WDG)) i_isorw_channel (.clk, .rst_b,
    .channel_a_input(pin), .side1_enable_b(en_b), .side1_powered(pwr), .side2_enable_b(en_b),
    .channel_a_output(out), .watchdog_tripped(trip));
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hBB2A3672));
    step(16);
    rst_b <= 1'b1;
    step(40);
    `CHK("refreshed", 1'b0, out)
    for (int i = 0; i < 24; i++) begin
      v = 1'($urandom);
      lvl <= v;
      step(12);
      `CHK("edge", expect_out(1'b1, 1'b1, v, 1'b0), out)
    end
    en_b <= 1'b1;
    step(8);
    for (int i = 1; i >= 0; i--) begin
      lvl <= 1'(i);
      step(12);
      `CHK("lp edge", 1'(i), out)
    end
    pwr <= 1'b0;
    step(60);
    `CHK("held", expect_out(1'b0, 1'b0, 1'b1, 1'b0), out)
    `CHK("quiet", 1'b0, trip)
    en_b <= 1'b0;
    step(60);
    `CHK("default", expect_out(1'b1, 1'b0, 1'b0, 1'b0), out)
    `CHK("tripped", 1'b1, trip)
    pwr <= 1'b1;
    step(REF + 30);
    `CHK("recovered", 1'b0, out)
    `CHK("cleared", 1'b0, trip)
    en_b <= 1'b1;
    step(8);
    pwr <= 1'b0;
    lvl <= 1'b1;
    step(6);
    pwr <= 1'b1;
    step(40);
    `CHK("stale", 1'b0, out)
    // Refresh, left on from here to the end, forces alignment after power-up
    en_b <= 1'b0;
    step(REF + 30);
    `CHK("aligned", 1'b1, out)
    // Reset in mid-run with the input high
    rst_b <= 1'b0;
    step(2);
    `CHK("reset out", 1'b0, out)
    `CHK("reset trip", 1'b0, trip)
    rst_b <= 1'b1;
    step(40);
    `CHK("after reset", 1'b1, out)
    wrap_up();
  end
endmodule
